// ===== hdl/status_service_request_trigger.sv
// Status summary byte, service request and trigger arming for an instrument interface.
// Assumes command strobes are one-cycle pulses synchronous to core_clk.
//
// Summary of operation
// - Eight-bit summary: operation, master, event, message, questionable bits; 1,0 unused.
// - Bit 2 set while the error queue holds at least one error.
// - Mask read returns the enable mask, same layout as summary byte.
// - Mask bit one lets matching summary bit request service; zero blocks it.
// - Status query returns summary byte with master summary in bit 6, unchanged.
// - Summary clears only when its causes clear; reading never clears it.
// - Master summary high while any enabled reason exists, low otherwise.
// - Serial poll returns request flag in bit 6 and clears that flag, unless master summary rises in the same cycle.
// - Waiting-for-trigger bit shows arming; trigger pulses only while armed.
// - Accepted trigger loads preset voltage and current, clears waiting bit.
// - With continuous arming, rearm at once and set waiting bit again.
// - Trigger command and bus GET act only while addressed as listener.
// - Self-test returns zero on full pass, else nonzero failure code.
// - Every subtest runs even after failure; each failure sets own bit.
// - Bit 6 is the OR of summary bits whose mask bit is set.
// - Mask writes ignore bit 6; it always reads back as zero.
// - After a single-armed trigger, further triggers ignored until rearmed.
`timescale 1ns/10ps
module status_service_request_trigger (
	// Clock and reset
	input wire logic core_clk,
	input wire logic sys_rst,
	// Status conditions from the rest of the card
	input wire ssr_pkg::status_conditions_t conditions,
	// Controller commands and addressing
	input wire ssr_pkg::controller_cmd_t cmd,
	input wire logic listener_addressed,
	// Subtest handshake
	output logic subtest_active,
	output logic [$clog2(ssr_pkg::SUBTEST_COUNT)-1:0] subtest_sel,
	input wire logic subtest_fail,
	// Replies to the controller
	output logic [ssr_pkg::BYTE_W-1:0] reply_data,
	output logic reply_valid,
	// Service request and trigger outputs
	output logic service_request_out,
	output logic waiting_for_trigger,
	output logic trigger_pulse,
	output logic [ssr_pkg::SETPOINT_W-1:0] voltage_setpoint,
	output logic [ssr_pkg::SETPOINT_W-1:0] current_setpoint
);

	// ==========================================================
	// Declarations
	ssr_pkg::ctrl_state_t st_reg;
	ssr_pkg::ctrl_state_t st_next;
	logic [ssr_pkg::BYTE_W-1:0] raw_summary;
	logic [ssr_pkg::BYTE_W-1:0] enabled_bits;
	logic [ssr_pkg::BYTE_W-1:0] summary_byte;
	logic master_summary;
	logic master_rise;
	logic trigger_accept;
	logic test_done;
	logic [ssr_pkg::SUBTEST_COUNT-1:0] test_code;

	// ==========================================================
	// Summary byte, purely combinational so it only clears with its causes
	always_comb begin
		raw_summary = '0; // Bits 1 and 0 stay zero
		raw_summary[ssr_pkg::BIT_OPERATION] = conditions.operation_summary;
		raw_summary[ssr_pkg::BIT_EVENT] = conditions.event_summary;
		raw_summary[ssr_pkg::BIT_MESSAGE] = conditions.message_available_flag;
		raw_summary[ssr_pkg::BIT_QUESTIONABLE] = conditions.questionable_summary;
		raw_summary[ssr_pkg::BIT_ERROR_QUEUE] = (conditions.error_count != '0);
	end

	// Per-bit enable gating
	genvar gi;
	generate
		for (gi = 0; gi < ssr_pkg::BYTE_W; gi++) begin : g_enable
			assign enabled_bits[gi] = raw_summary[gi] & st_reg.service_request_mask_reg[gi];
		end
	endgenerate

	// Master summary and full byte; no stored copy, so reads cannot clear it
	assign master_summary = |enabled_bits;
	always_comb begin
		summary_byte = raw_summary;
		summary_byte[ssr_pkg::BIT_MASTER] = master_summary;
	end
	assign master_rise = master_summary & ~st_reg.master_prev;

	// Trigger acceptance needs arming and listener addressing
	assign trigger_accept = (cmd.trigger_cmd | cmd.bus_get) & listener_addressed
		& st_reg.waiting_for_trigger;

	// ==========================================================
	// Self-test runner
	self_test_collector #(
		.NUM_SUBTESTS(ssr_pkg::SUBTEST_COUNT)
	) u_self_test (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.start(cmd.self_test),
		.done(test_done),
		.fail_code(test_code),
		.subtest_active(subtest_active),
		.subtest_sel(subtest_sel),
		.subtest_fail(subtest_fail)
	);

	// ==========================================================
	// Next state
	always_comb begin
		st_next = st_reg;
		st_next.trigger_pulse = 1'b0;
		st_next.reply_valid = 1'b0;
		st_next.master_prev = master_summary;

		// Mask write; bit 6 cannot be programmed
		if (cmd.mask_write) begin
			st_next.service_request_mask_reg = cmd.data[ssr_pkg::BYTE_W-1:0]
				& ssr_pkg::MASK_WRITABLE;
		end

		// Poll clears the flag, but a new rising edge the same cycle wins
		if (cmd.serial_poll) begin
			st_next.request_service_flag = 1'b0;
		end
		if (master_rise) begin
			st_next.request_service_flag = 1'b1;
		end

		// Reply mux; the poll outranks the queries if two arrive together
		if (cmd.serial_poll) begin
			st_next.reply_data = summary_byte;
			st_next.reply_data[ssr_pkg::BIT_MASTER] = st_reg.request_service_flag;
			st_next.reply_valid = 1'b1;
		end else if (cmd.status_query) begin
			st_next.reply_data = summary_byte;
			st_next.reply_valid = 1'b1;
		end else if (cmd.mask_read) begin
			st_next.reply_data = st_reg.service_request_mask_reg;
			st_next.reply_valid = 1'b1;
		end else if (test_done) begin
			// Zero only if no subtest set its bit
			st_next.reply_data = test_code;
			st_next.reply_valid = 1'b1;
		end

		// Preset levels
		if (cmd.preset_voltage_write) begin
			st_next.preset_trigger_voltage = cmd.data;
		end
		if (cmd.preset_current_write) begin
			st_next.preset_trigger_current = cmd.data;
		end

		// Arming mode
		if (cmd.continuous_off) begin
			st_next.continuous_arming = 1'b0;
		end
		if (cmd.continuous_on) begin
			st_next.continuous_arming = 1'b1;
		end

		// Firing: old preset values are loaded even if rewritten this cycle
		if (trigger_accept) begin
			st_next.voltage_setpoint = st_reg.preset_trigger_voltage;
			st_next.current_setpoint = st_reg.preset_trigger_current;
			st_next.trigger_pulse = 1'b1;
			st_next.waiting_for_trigger = st_reg.continuous_arming;
		end

		// Arming commands override a clear from a trigger in the same cycle
		if (cmd.arm_single | cmd.continuous_on) begin
			st_next.waiting_for_trigger = 1'b1;
		end
	end

	// ==========================================================
	// State register
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign reply_data = st_reg.reply_data;
	assign reply_valid = st_reg.reply_valid;
	assign service_request_out = st_reg.request_service_flag;
	assign waiting_for_trigger = st_reg.waiting_for_trigger;
	assign trigger_pulse = st_reg.trigger_pulse;
	assign voltage_setpoint = st_reg.voltage_setpoint;
	assign current_setpoint = st_reg.current_setpoint;

	// ==========================================================
	// Assertions
	sequence s_armed_trigger;
		(cmd.trigger_cmd | cmd.bus_get) && listener_addressed && waiting_for_trigger;
	endsequence

	sequence s_fired_single;
		s_armed_trigger ##0 !st_reg.continuous_arming && !cmd.arm_single && !cmd.continuous_on;
	endsequence

	property p_mask_bit6_zero;
		@(posedge core_clk) disable iff (sys_rst)
		st_reg.service_request_mask_reg[ssr_pkg::BIT_MASTER] == 1'b0;
	endproperty
	a_mask_bit6_zero: assert property (p_mask_bit6_zero) else $error("mask bit 6 set");

	property p_mask_readback;
		@(posedge core_clk) disable iff (sys_rst)
		cmd.mask_read && !cmd.serial_poll && !cmd.status_query
		|=> reply_valid && reply_data == $past(st_reg.service_request_mask_reg);
	endproperty
	a_mask_readback: assert property (p_mask_readback) else $error("mask read wrong");

	property p_query_master;
		@(posedge core_clk) disable iff (sys_rst)
		cmd.status_query && !cmd.serial_poll
		|=> reply_data[ssr_pkg::BIT_MASTER] == $past(|({conditions.operation_summary, 1'b0,
			conditions.event_summary, conditions.message_available_flag,
			conditions.questionable_summary, conditions.error_count != '0, 2'b00}
			& st_reg.service_request_mask_reg));
	endproperty
	a_query_master: assert property (p_query_master) else $error("query bit 6 wrong");

	property p_error_bit;
		@(posedge core_clk) disable iff (sys_rst)
		cmd.status_query && !cmd.serial_poll && conditions.error_count != '0
		|=> reply_data[ssr_pkg::BIT_ERROR_QUEUE];
	endproperty
	a_error_bit: assert property (p_error_bit) else $error("error queue bit missing");

	property p_poll_reply;
		@(posedge core_clk) disable iff (sys_rst)
		cmd.serial_poll |=> reply_valid && reply_data[ssr_pkg::BIT_MASTER] == $past(service_request_out);
	endproperty
	a_poll_reply: assert property (p_poll_reply) else $error("poll bit 6 wrong");

	property p_poll_clears;
		@(posedge core_clk) disable iff (sys_rst)
		cmd.serial_poll && !master_rise |=> !service_request_out;
	endproperty
	a_poll_clears: assert property (p_poll_clears) else $error("poll left flag set");

	property p_rise_sets_flag;
		@(posedge core_clk) disable iff (sys_rst)
		master_rise |=> service_request_out;
	endproperty
	a_rise_sets_flag: assert property (p_rise_sets_flag) else $error("flag not set");

	property p_fire_loads;
		@(posedge core_clk) disable iff (sys_rst)
		s_armed_trigger |=> trigger_pulse && voltage_setpoint == $past(st_reg.preset_trigger_voltage)
			&& current_setpoint == $past(st_reg.preset_trigger_current);
	endproperty
	a_fire_loads: assert property (p_fire_loads) else $error("trigger did not load");

	property p_pulse_cause;
		@(posedge core_clk) disable iff (sys_rst)
		trigger_pulse |-> $past(waiting_for_trigger) && $past(listener_addressed);
	endproperty
	a_pulse_cause: assert property (p_pulse_cause) else $error("unarmed trigger");

	property p_single_disarms;
		@(posedge core_clk) disable iff (sys_rst)
		s_fired_single |=> !waiting_for_trigger;
	endproperty
	a_single_disarms: assert property (p_single_disarms) else $error("single arm kept");

endmodule

// ===== hdl/ssr_pkg.sv
// Shared constants and carriers for the status, service request and trigger block.
// Assumes a single 20 MHz core clock; command strobes are one-cycle pulses.
package ssr_pkg;

	// ==========================================================
	// Summary byte field positions
	localparam int BIT_OPERATION = 7;
	localparam int BIT_MASTER = 6;
	localparam int BIT_EVENT = 5;
	localparam int BIT_MESSAGE = 4;
	localparam int BIT_QUESTIONABLE = 3;
	localparam int BIT_ERROR_QUEUE = 2;

	// ==========================================================
	// Widths and reset values
	localparam int BYTE_W = 8;
	localparam int SETPOINT_W = 16;
	localparam int ERR_COUNT_W = 8;
	localparam int SUBTEST_COUNT = 8;
	localparam logic [BYTE_W-1:0] MASK_RESET = 8'h00;
	localparam logic [BYTE_W-1:0] MASK_WRITABLE = 8'hBC;
	localparam logic [BYTE_W-1:0] SELF_TEST_PASS = 8'h00;

	// ==========================================================
	// Carriers
	typedef struct packed {
		logic operation_summary;
		logic event_summary;
		logic message_available_flag;
		logic questionable_summary;
		logic [ERR_COUNT_W-1:0] error_count;
	} status_conditions_t;

	typedef struct packed {
		logic mask_write;
		logic mask_read;
		logic status_query;
		logic serial_poll;
		logic trigger_cmd;
		logic bus_get;
		logic arm_single;
		logic continuous_on;
		logic continuous_off;
		logic preset_voltage_write;
		logic preset_current_write;
		logic self_test;
		logic [SETPOINT_W-1:0] data;
	} controller_cmd_t;

	typedef struct packed {
		logic [BYTE_W-1:0] service_request_mask_reg;
		logic request_service_flag;
		logic master_prev;
		logic waiting_for_trigger;
		logic continuous_arming;
		logic trigger_pulse;
		logic [SETPOINT_W-1:0] preset_trigger_voltage;
		logic [SETPOINT_W-1:0] preset_trigger_current;
		logic [SETPOINT_W-1:0] voltage_setpoint;
		logic [SETPOINT_W-1:0] current_setpoint;
		logic [BYTE_W-1:0] reply_data;
		logic reply_valid;
	} ctrl_state_t;

endpackage

// ===== hdl/self_test_collector.sv
// Sequential self-test runner: steps through every subtest and gathers fail bits.
// Assumes subtest_fail answers for the subtest named by subtest_sel in the same cycle.
`timescale 1ns/10ps
module self_test_collector #(
	parameter int NUM_SUBTESTS = 8
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic sys_rst,
	// Control
	input wire logic start,
	output logic done,
	output logic [NUM_SUBTESTS-1:0] fail_code,
	// Subtest handshake
	output logic subtest_active,
	output logic [$clog2(NUM_SUBTESTS)-1:0] subtest_sel,
	input wire logic subtest_fail
);

	// ==========================================================
	// State
	localparam int IW = $clog2(NUM_SUBTESTS);
	typedef enum logic {ST_IDLE, ST_RUN} test_phase_t;
	typedef struct packed {
		test_phase_t phase;
		logic [IW-1:0] idx;
		logic [NUM_SUBTESTS-1:0] code;
		logic done;
	} test_state_t;
	test_state_t st_reg;
	test_state_t st_next;

	// Next state; a start while running is ignored
	always_comb begin
		st_next = st_reg;
		st_next.done = 1'b0;
		case (st_reg.phase)
			ST_IDLE: begin
				if (start) begin
					st_next.phase = ST_RUN;
					st_next.idx = '0;
					st_next.code = '0;
				end
			end
			ST_RUN: begin
				// A failure never stops the run; each fail sets its own bit
				st_next.code[st_reg.idx] = st_reg.code[st_reg.idx] | subtest_fail;
				if (st_reg.idx == IW'(NUM_SUBTESTS - 1)) begin
					st_next.phase = ST_IDLE;
					st_next.done = 1'b1;
				end else begin
					st_next.idx = st_reg.idx + 1'b1;
				end
			end
			default: st_next.phase = ST_IDLE;
		endcase
	end

	// State register
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign done = st_reg.done;
	assign fail_code = st_reg.code;
	assign subtest_active = (st_reg.phase == ST_RUN);
	assign subtest_sel = st_reg.idx;

endmodule

// ===== sim/bus_controller_model.sv
// Far-side model: a bus controller issuing one-cycle command strobes, plus subtest answers.
// Assumes the block samples on the rising edge of core_clk; strobes launch off the falling edge.
`timescale 1ns/10ps
module bus_controller_model (
	// Clock
	input wire logic core_clk,
	// Commands and addressing
	output ssr_pkg::controller_cmd_t cmd,
	output logic listener_addressed,
	// Subtest answers
	input wire logic subtest_active,
	input wire logic [$clog2(ssr_pkg::SUBTEST_COUNT)-1:0] subtest_sel,
	output logic subtest_fail
);
	// ==========================================================
	// Subtest responder
	logic [7:0] pattern = 8'h00;
	logic idle_tog = 1'b0;

	// Idle line wanders so a stale sample cannot pass
	always @(posedge core_clk) begin
		idle_tog <= ~idle_tog;
	end
	assign subtest_fail = subtest_active ? pattern[subtest_sel] : idle_tog;

	// ==========================================================
	// Command strobes, codes in the bench's order
	initial begin
		cmd = '0;
		listener_addressed = 1'b0;
	end

	task automatic send(input int k, input logic [15:0] d);
		ssr_pkg::controller_cmd_t c;
		c = '0;
		c.data = d;
		case (k)
			0: c.mask_write = 1'b1;
			1: c.mask_read = 1'b1;
			2: c.status_query = 1'b1;
			3: c.serial_poll = 1'b1;
			4: c.trigger_cmd = 1'b1;
			5: c.bus_get = 1'b1;
			6: c.arm_single = 1'b1;
			7: c.continuous_on = 1'b1;
			8: c.continuous_off = 1'b1;
			9: c.preset_voltage_write = 1'b1;
			10: c.preset_current_write = 1'b1;
			default: c.self_test = 1'b1;
		endcase
		@(negedge core_clk);
		cmd = c;
		@(negedge core_clk);
		cmd = '0;
	endtask
endmodule

// ===== sim/tb_top.sv
// Self-checking bench for the status, service request and trigger block.
// Assumes the controller model's strobes; every check is taken at a falling edge.
`timescale 1ns/10ps
module tb_top;
	// ==========================================================
	// Signals
	typedef enum int {K_MWR, K_MRD, K_QRY, K_POLL, K_TRIG, K_GET, K_ARM, K_CON, K_COFF,
		K_PVOLT, K_PCURR, K_TEST} op_t;
	localparam logic [7:0] REASONS [5] = '{8'h80, 8'h20, 8'h10, 8'h08, 8'h04};
	localparam logic [7:0] PATTERNS [2] = '{8'h00, 8'hA5};
	logic core_clk = 1'b0;
	logic sys_rst = 1'b1;
	ssr_pkg::status_conditions_t conditions = '0;
	ssr_pkg::controller_cmd_t cmd;
	logic listener_addressed, subtest_active, subtest_fail, reply_valid;
	logic service_request_out, waiting_for_trigger, trigger_pulse;
	logic [2:0] subtest_sel;
	logic [7:0] reply_data;
	logic [15:0] voltage_setpoint, current_setpoint;
	int bad_count = 0;
	int check_count = 0;
	int i;

	// ==========================================================
	// Clock, design and far side
	initial begin
		forever #25 core_clk = ~core_clk;
	end

	status_service_request_trigger dut (.core_clk(core_clk), .sys_rst(sys_rst),
		.conditions(conditions), .cmd(cmd), .listener_addressed(listener_addressed),
		.subtest_active(subtest_active), .subtest_sel(subtest_sel),
		.subtest_fail(subtest_fail), .reply_data(reply_data), .reply_valid(reply_valid),
		.service_request_out(service_request_out), .waiting_for_trigger(waiting_for_trigger),
		.trigger_pulse(trigger_pulse), .voltage_setpoint(voltage_setpoint),
		.current_setpoint(current_setpoint));

	bus_controller_model ctrl (.core_clk(core_clk), .cmd(cmd),
		.listener_addressed(listener_addressed), .subtest_active(subtest_active),
		.subtest_sel(subtest_sel), .subtest_fail(subtest_fail));

	// ==========================================================
	// Compare and access tasks
	task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			bad_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Reply pulse must be present in the cycle it is looked at
	task automatic chk_reply(input logic [7:0] exp);
		chk_val({15'h0000, reply_valid}, 16'h0001);
		chk_val({8'h00, reply_data}, {8'h00, exp});
	endtask

	task automatic ask(input int k, input logic [7:0] exp);
		ctrl.send(k, 16'h0000);
		chk_reply(exp);
	endtask

	task automatic set_cond(input logic [7:0] b);
		@(negedge core_clk);
		conditions.operation_summary = b[7];
		conditions.event_summary = b[5];
		conditions.message_available_flag = b[4];
		conditions.questionable_summary = b[3];
		conditions.error_count = b[2] ? 8'h01 : 8'h00;
	endtask

	task automatic results;
		$display("Checks %0d, errors %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// Self-test reply comes late; a bound keeps a hang from stalling the run
	task automatic wait_reply;
		int n = 0;
		while (reply_valid !== 1'b1 && n < 20) begin
			@(negedge core_clk);
			n++;
		end
		if (reply_valid !== 1'b1) begin
			bad_count++;
			results();
		end
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		repeat (5) @(negedge core_clk);
		sys_rst = 1'b0;
		ask(K_MRD, 8'h00);
		chk_val({14'h0, service_request_out, waiting_for_trigger}, 16'h0000);
		ctrl.send(K_MWR, 16'h00FF);
		ask(K_MRD, 8'hBC);
		ctrl.send(K_MWR, 16'h0020);
		ask(K_MRD, 8'h20);
		ask(K_QRY, 8'h00);
		set_cond(8'h24);
		@(negedge core_clk);
		chk_val({15'h0, service_request_out}, 16'h0001);
		ask(K_QRY, 8'h64);
		ask(K_QRY, 8'h64);
		chk_val({15'h0, service_request_out}, 16'h0001);
		ask(K_POLL, 8'h64);
		chk_val({15'h0, service_request_out}, 16'h0000);
		ask(K_POLL, 8'h24);
		ask(K_QRY, 8'h64);
		// Each reason alone, enabled then blocked
		for (i = 0; i < 5; i++) begin
			set_cond(REASONS[i]);
			ctrl.send(K_MWR, {8'h00, REASONS[i]});
			ask(K_QRY, REASONS[i] | 8'h40);
			ctrl.send(K_MWR, {8'h00, 8'hBC & ~REASONS[i]});
			ask(K_QRY, REASONS[i]);
		end
		set_cond(8'h00);
		ctrl.send(K_MWR, 16'h00BC);
		ask(K_QRY, 8'h00);
		ask(K_POLL, 8'h40);
		ask(K_POLL, 8'h00);
		// Trigger arming
		ctrl.send(K_PVOLT, 16'h1234);
		ctrl.send(K_PCURR, 16'h0ABC);
		ctrl.listener_addressed = 1'b1;
		ctrl.send(K_TRIG, 16'h0000);
		chk_val({15'h0, trigger_pulse}, 16'h0000);
		ctrl.send(K_ARM, 16'h0000);
		chk_val({15'h0, waiting_for_trigger}, 16'h0001);
		ctrl.listener_addressed = 1'b0;
		ctrl.send(K_GET, 16'h0000);
		chk_val({15'h0, trigger_pulse}, 16'h0000);
		ctrl.listener_addressed = 1'b1;
		ctrl.send(K_TRIG, 16'h0000);
		chk_val({14'h0, trigger_pulse, waiting_for_trigger}, 16'h0002);
		chk_val(voltage_setpoint, 16'h1234);
		chk_val(current_setpoint, 16'h0ABC);
		ctrl.send(K_PVOLT, 16'h5678);
		ctrl.send(K_TRIG, 16'h0000);
		chk_val({trigger_pulse, voltage_setpoint[14:0]}, 16'h1234);
		ctrl.send(K_CON, 16'h0000);
		ctrl.send(K_GET, 16'h0000);
		chk_val({14'h0, trigger_pulse, waiting_for_trigger}, 16'h0003);
		chk_val(voltage_setpoint, 16'h5678);
		ctrl.send(K_COFF, 16'h0000);
		ctrl.send(K_TRIG, 16'h0000);
		chk_val({14'h0, trigger_pulse, waiting_for_trigger}, 16'h0002);
		// Self-test, clean and with scattered failures
		for (i = 0; i < 2; i++) begin
			ctrl.pattern = PATTERNS[i];
			ctrl.send(K_TEST, 16'h0000);
			wait_reply();
			chk_reply(PATTERNS[i]);
		end
		results();
	end
endmodule
